// file: hw/esip_defines.svh
// Constants for the Ethernet statistics increment pulse block.
// Assumes frame lengths are byte counts that include the FCS.
`ifndef ESIP_DEFINES_SVH
`define ESIP_DEFINES_SVH

// Size bin bounds, in bytes
`define ESIP_LEN_64   16'h0040
`define ESIP_LEN_127  16'h007f
`define ESIP_LEN_128  16'h0080
`define ESIP_LEN_255  16'h00ff
`define ESIP_LEN_256  16'h0100
`define ESIP_LEN_511  16'h01ff
`define ESIP_LEN_512  16'h0200
`define ESIP_LEN_1023 16'h03ff
`define ESIP_LEN_1024 16'h0400
`define ESIP_LEN_1518 16'h05ee

// Bin vector positions
`define ESIP_BIN_64   0
`define ESIP_BIN_127  1
`define ESIP_BIN_255  2
`define ESIP_BIN_511  3
`define ESIP_BIN_1023 4
`define ESIP_BIN_1518 5
`define ESIP_NBINS    6

// Increment vector positions, shared by TX and RX
`define ESIP_I_64         0
`define ESIP_I_127        1
`define ESIP_I_255        2
`define ESIP_I_511        3
`define ESIP_I_1023       4
`define ESIP_I_1518       5
`define ESIP_I_MAX        6
`define ESIP_I_OVER       7
`define ESIP_I_MC_DERR    8
`define ESIP_I_MC_DOK     9
`define ESIP_I_BC_DERR    10
`define ESIP_I_BC_DOK     11
`define ESIP_I_UC_DERR    12
`define ESIP_I_UC_DOK     13
`define ESIP_I_MC_CTRL    14
`define ESIP_I_BC_CTRL    15
`define ESIP_I_UC_CTRL    16
`define ESIP_I_PAUSE      17
`define ESIP_I_FCS        18
`define ESIP_I_FRAG       19
`define ESIP_I_JABBER     20
`define ESIP_I_SZOK_FCS   21
`define ESIP_TX_NINC      22
// RX only
`define ESIP_I_RUNT       22
`define ESIP_I_PAUSE_CERR 23
`define ESIP_I_MC_CERR    24
`define ESIP_I_BC_CERR    25
`define ESIP_I_UC_CERR    26
`define ESIP_RX_NINC      27

`endif

// file: hw/esip_pkg.sv
// Types for the Ethernet statistics increment pulse block.
// Assumes the MAC front end reports the destination cast type per frame.
package esip_pkg;

	typedef enum logic [1:0] {
		ESIP_UCAST,
		ESIP_MCAST,
		ESIP_BCAST
	} esip_cast_t;

endpackage

// file: hw/esip_bins.sv
// Frame length classifier: size bins, maximum, oversize and undersize.
// Assumes a length and limit that are stable while the caller samples them.
`timescale 1ns/1ps
`include "esip_defines.svh"

module esip_bins #(
	parameter int LEN_W = 16
) (
	input  wire logic [LEN_W-1:0]        frame_len,
	input  wire logic [LEN_W-1:0]        max_size,
	output logic      [`ESIP_NBINS-1:0]  bin_hit,
	output logic                         max_hit,
	output logic                         over,
	output logic                         under
);

	wire logic [15:0] len16;

	assign len16 = 16'(frame_len);

	assign bin_hit[`ESIP_BIN_64]   = len16 == `ESIP_LEN_64;
	assign bin_hit[`ESIP_BIN_127]  = len16 > `ESIP_LEN_64 && len16 <= `ESIP_LEN_127;
	assign bin_hit[`ESIP_BIN_255]  = len16 >= `ESIP_LEN_128 && len16 <= `ESIP_LEN_255;
	assign bin_hit[`ESIP_BIN_511]  = len16 >= `ESIP_LEN_256 && len16 <= `ESIP_LEN_511;
	assign bin_hit[`ESIP_BIN_1023] = len16 >= `ESIP_LEN_512 && len16 <= `ESIP_LEN_1023;
	assign bin_hit[`ESIP_BIN_1518] = len16 >= `ESIP_LEN_1024 && len16 <= `ESIP_LEN_1518;

	assign max_hit = frame_len == max_size;
	assign over    = frame_len > max_size;
	assign under   = len16 < `ESIP_LEN_64;

endmodule

// file: hw/esip_top.sv
// Per-frame statistics increment pulses for a TX and an RX MAC path.
// Assumes a one-cycle frame-done strobe per path with length and status valid.
//
// What this block does
// RL1 - TX pulses 64, 65-127 or 128-255 bin
// RL2 - TX pulses 256-511, 512-1023 or 1024-1518 bin
// RL3 - TX pulses max when length equals limit
// RL4 - TX pulses oversize when length exceeds limit
// RL5 - TX data frames pulse cast by ok/err
// RL6 - TX valid control frames pulse by cast
// RL7 - TX valid pause frame pulses pause
// RL8 - TX FCS errored frame pulses fcs error
// RL9 - TX under 64 with CRC error: fragment
// RL10 - TX oversize with CRC error: jabber
// RL11 - TX valid size with FCS error pulses
// RL12 - RX runt frame pulses runt output
// RL13 - RX pulses 64, 65-127 or 128-255 bin
// RL14 - RX pulses 256-511, 512-1023 or 1024-1518 bin
// RL15 - RX pulses max when length equals limit
// RL16 - RX pulses oversize when length exceeds limit
// RL17 - RX data frames pulse cast by ok/err
// RL18 - RX valid control frames pulse by cast
// RL19 - RX valid pause frame pulses pause
// RL20 - RX fcs error and size-ok fcs error
// RL21 - RX fragment and jabber on CRC error
// RL22 - RX errored pause and control frames pulse
// RL23 - Both paths pulse in the one shared clock
// RL24 - Pulses always driven, counters or not
// RL25 - Pulses go out and to counters
// RL26 - All pulses once, cycle after frame end
`timescale 1ns/1ps
`include "esip_defines.svh"

module esip_top #(
	parameter int LEN_W = 16
) (
	input  wire logic                        clock,
	input  wire logic                        rst_n,
	input  wire logic                        tx_frame_done,
	input  wire logic [LEN_W-1:0]            tx_frame_len,
	input  wire logic                        tx_fcs_err,
	input  wire logic                        tx_is_ctrl,
	input  wire logic                        tx_is_pause,
	input  wire esip_pkg::esip_cast_t        tx_cast,
	input  wire logic [LEN_W-1:0]            tx_max_size,
	input  wire logic                        rx_frame_done,
	input  wire logic [LEN_W-1:0]            rx_frame_len,
	input  wire logic                        rx_fcs_err,
	input  wire logic                        rx_is_ctrl,
	input  wire logic                        rx_is_pause,
	input  wire esip_pkg::esip_cast_t        rx_cast,
	input  wire logic [LEN_W-1:0]            rx_max_size,
	output logic [`ESIP_TX_NINC-1:0]         tx_stat_inc,
	output logic [`ESIP_RX_NINC-1:0]         rx_stat_inc,
	output logic                             tx_inc_64,
	output logic                             tx_inc_127,
	output logic                             tx_inc_255,
	output logic                             tx_inc_511,
	output logic                             tx_inc_1023,
	output logic                             tx_inc_1518,
	output logic                             tx_inc_max,
	output logic                             tx_inc_over,
	output logic                             tx_inc_mcast_data_err,
	output logic                             tx_inc_mcast_data_ok,
	output logic                             tx_inc_bcast_data_err,
	output logic                             tx_inc_bcast_data_ok,
	output logic                             tx_inc_ucast_data_err,
	output logic                             tx_inc_ucast_data_ok,
	output logic                             tx_inc_mcast_ctrl,
	output logic                             tx_inc_bcast_ctrl,
	output logic                             tx_inc_ucast_ctrl,
	output logic                             tx_inc_pause,
	output logic                             tx_inc_fcs_err,
	output logic                             tx_inc_fragment,
	output logic                             tx_inc_jabber,
	output logic                             tx_inc_sizeok_fcserr,
	output logic                             rx_inc_runt,
	output logic                             rx_inc_64,
	output logic                             rx_inc_127,
	output logic                             rx_inc_255,
	output logic                             rx_inc_511,
	output logic                             rx_inc_1023,
	output logic                             rx_inc_1518,
	output logic                             rx_inc_max,
	output logic                             rx_inc_over,
	output logic                             rx_inc_mcast_data_err,
	output logic                             rx_inc_mcast_data_ok,
	output logic                             rx_inc_bcast_data_err,
	output logic                             rx_inc_bcast_data_ok,
	output logic                             rx_inc_ucast_data_err,
	output logic                             rx_inc_ucast_data_ok,
	output logic                             rx_inc_mcast_ctrl,
	output logic                             rx_inc_bcast_ctrl,
	output logic                             rx_inc_ucast_ctrl,
	output logic                             rx_inc_pause,
	output logic                             rx_inc_fcs_err,
	output logic                             rx_inc_fragment,
	output logic                             rx_inc_jabber,
	output logic                             rx_inc_sizeok_fcserr,
	output logic                             rx_inc_pause_ctrl_err,
	output logic                             rx_inc_mcast_ctrl_err,
	output logic                             rx_inc_bcast_ctrl_err,
	output logic                             rx_inc_ucast_ctrl_err
);

	////////////////////////////////////////////////////////////////////////////
	// Length classification

	logic [`ESIP_NBINS-1:0] tx_bin;
	logic                   tx_max_hit;
	logic                   tx_over;
	logic                   tx_under;
	logic [`ESIP_NBINS-1:0] rx_bin;
	logic                   rx_max_hit;
	logic                   rx_over;
	logic                   rx_under;

	esip_bins #(
		.LEN_W     (LEN_W)
	) u_tx_bins (
		.frame_len (tx_frame_len),
		.max_size  (tx_max_size),
		.bin_hit   (tx_bin),
		.max_hit   (tx_max_hit),
		.over      (tx_over),
		.under     (tx_under)
	);

	esip_bins #(
		.LEN_W     (LEN_W)
	) u_rx_bins (
		.frame_len (rx_frame_len),
		.max_size  (rx_max_size),
		.bin_hit   (rx_bin),
		.max_hit   (rx_max_hit),
		.over      (rx_over),
		.under     (rx_under)
	);

	////////////////////////////////////////////////////////////////////////////
	// TX decode

	wire logic tx_err;
	wire logic tx_data;
	wire logic tx_ctrl_ok;
	wire logic tx_mc;
	wire logic tx_bc;
	wire logic tx_uc;
	logic [`ESIP_TX_NINC-1:0] tx_inc_nxt;
	logic [`ESIP_TX_NINC-1:0] tx_inc_r;

	// A frame counts as errored on FCS error or a size violation
	assign tx_err     = tx_fcs_err | tx_over | tx_under;
	assign tx_data    = ~tx_is_ctrl & ~tx_is_pause;
	assign tx_ctrl_ok = (tx_is_ctrl | tx_is_pause) & ~tx_err;
	assign tx_mc      = tx_cast == esip_pkg::ESIP_MCAST;
	assign tx_bc      = tx_cast == esip_pkg::ESIP_BCAST;
	assign tx_uc      = tx_cast == esip_pkg::ESIP_UCAST;

	assign tx_inc_nxt[`ESIP_I_1518:`ESIP_I_64] = tx_bin; // [RL1] [RL2]
	assign tx_inc_nxt[`ESIP_I_MAX]      = tx_max_hit; // [RL3]
	assign tx_inc_nxt[`ESIP_I_OVER]     = tx_over; // [RL4]
	assign tx_inc_nxt[`ESIP_I_MC_DERR]  = tx_data & tx_mc & tx_err; // [RL5]
	assign tx_inc_nxt[`ESIP_I_MC_DOK]   = tx_data & tx_mc & ~tx_err; // [RL5]
	assign tx_inc_nxt[`ESIP_I_BC_DERR]  = tx_data & tx_bc & tx_err; // [RL5]
	assign tx_inc_nxt[`ESIP_I_BC_DOK]   = tx_data & tx_bc & ~tx_err; // [RL5]
	assign tx_inc_nxt[`ESIP_I_UC_DERR]  = tx_data & tx_uc & tx_err; // [RL5]
	assign tx_inc_nxt[`ESIP_I_UC_DOK]   = tx_data & tx_uc & ~tx_err; // [RL5]
	assign tx_inc_nxt[`ESIP_I_MC_CTRL]  = tx_ctrl_ok & tx_mc; // [RL6]
	assign tx_inc_nxt[`ESIP_I_BC_CTRL]  = tx_ctrl_ok & tx_bc; // [RL6]
	assign tx_inc_nxt[`ESIP_I_UC_CTRL]  = tx_ctrl_ok & tx_uc; // [RL6]
	assign tx_inc_nxt[`ESIP_I_PAUSE]    = tx_is_pause & ~tx_err; // [RL7]
	assign tx_inc_nxt[`ESIP_I_FCS]      = tx_fcs_err; // [RL8]
	assign tx_inc_nxt[`ESIP_I_FRAG]     = tx_under & tx_fcs_err; // [RL9]
	assign tx_inc_nxt[`ESIP_I_JABBER]   = tx_over & tx_fcs_err; // [RL10]
	assign tx_inc_nxt[`ESIP_I_SZOK_FCS] = ~tx_under & ~tx_over & tx_fcs_err; // [RL11]

	////////////////////////////////////////////////////////////////////////////
	// RX decode

	wire logic rx_err;
	wire logic rx_data;
	wire logic rx_ctrl_any;
	wire logic rx_ctrl_ok;
	wire logic rx_mc;
	wire logic rx_bc;
	wire logic rx_uc;
	logic [`ESIP_RX_NINC-1:0] rx_inc_nxt;
	logic [`ESIP_RX_NINC-1:0] rx_inc_r;

	// Errored: FCS error or a size violation
	// Pause frames count as control frames too
	assign rx_err      = rx_fcs_err | rx_over | rx_under;
	assign rx_data     = ~rx_is_ctrl & ~rx_is_pause;
	assign rx_ctrl_any = rx_is_ctrl | rx_is_pause;
	assign rx_ctrl_ok  = rx_ctrl_any & ~rx_err;
	assign rx_mc       = rx_cast == esip_pkg::ESIP_MCAST;
	assign rx_bc       = rx_cast == esip_pkg::ESIP_BCAST;
	assign rx_uc       = rx_cast == esip_pkg::ESIP_UCAST;

	assign rx_inc_nxt[`ESIP_I_1518:`ESIP_I_64] = rx_bin; // [RL13] [RL14]
	assign rx_inc_nxt[`ESIP_I_MAX]        = rx_max_hit; // [RL15]
	assign rx_inc_nxt[`ESIP_I_OVER]       = rx_over; // [RL16]
	assign rx_inc_nxt[`ESIP_I_MC_DERR]    = rx_data & rx_mc & rx_err; // [RL17]
	assign rx_inc_nxt[`ESIP_I_MC_DOK]     = rx_data & rx_mc & ~rx_err; // [RL17]
	assign rx_inc_nxt[`ESIP_I_BC_DERR]    = rx_data & rx_bc & rx_err; // [RL17]
	assign rx_inc_nxt[`ESIP_I_BC_DOK]     = rx_data & rx_bc & ~rx_err; // [RL17]
	assign rx_inc_nxt[`ESIP_I_UC_DERR]    = rx_data & rx_uc & rx_err; // [RL17]
	assign rx_inc_nxt[`ESIP_I_UC_DOK]     = rx_data & rx_uc & ~rx_err; // [RL17]
	assign rx_inc_nxt[`ESIP_I_MC_CTRL]    = rx_ctrl_ok & rx_mc; // [RL18]
	assign rx_inc_nxt[`ESIP_I_BC_CTRL]    = rx_ctrl_ok & rx_bc; // [RL18]
	assign rx_inc_nxt[`ESIP_I_UC_CTRL]    = rx_ctrl_ok & rx_uc; // [RL18]
	assign rx_inc_nxt[`ESIP_I_PAUSE]      = rx_is_pause & ~rx_err; // [RL19]
	assign rx_inc_nxt[`ESIP_I_FCS]        = rx_fcs_err; // [RL20]
	assign rx_inc_nxt[`ESIP_I_FRAG]       = rx_under & rx_fcs_err; // [RL21]
	assign rx_inc_nxt[`ESIP_I_JABBER]     = rx_over & rx_fcs_err; // [RL21]
	assign rx_inc_nxt[`ESIP_I_SZOK_FCS]   = ~rx_under & ~rx_over & rx_fcs_err; // [RL20]
	assign rx_inc_nxt[`ESIP_I_RUNT]       = rx_under; // [RL12]
	assign rx_inc_nxt[`ESIP_I_PAUSE_CERR] = rx_is_pause & rx_err; // [RL22]
	assign rx_inc_nxt[`ESIP_I_MC_CERR]    = rx_ctrl_any & rx_err & rx_mc; // [RL22]
	assign rx_inc_nxt[`ESIP_I_BC_CERR]    = rx_ctrl_any & rx_err & rx_bc; // [RL22]
	assign rx_inc_nxt[`ESIP_I_UC_CERR]    = rx_ctrl_any & rx_err & rx_uc; // [RL22]

	////////////////////////////////////////////////////////////////////////////
	// Pulse registers: one cycle after the frame-done strobe

	always_ff @(posedge clock) begin // [RL23]
		if (!rst_n) begin
			tx_inc_r <= '0;
		end else begin
			tx_inc_r <= tx_frame_done ? tx_inc_nxt : '0; // [RL26]
		end
	end

	always_ff @(posedge clock) begin // [RL23]
		if (!rst_n) begin
			rx_inc_r <= '0;
		end else begin
			rx_inc_r <= rx_frame_done ? rx_inc_nxt : '0; // [RL26]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs: counter increment vectors and named pulses

	assign tx_stat_inc = tx_inc_r; // [RL24] [RL25]
	assign rx_stat_inc = rx_inc_r; // [RL24] [RL25]

	assign tx_inc_64             = tx_inc_r[`ESIP_I_64];
	assign tx_inc_127            = tx_inc_r[`ESIP_I_127];
	assign tx_inc_255            = tx_inc_r[`ESIP_I_255];
	assign tx_inc_511            = tx_inc_r[`ESIP_I_511];
	assign tx_inc_1023           = tx_inc_r[`ESIP_I_1023];
	assign tx_inc_1518           = tx_inc_r[`ESIP_I_1518];
	assign tx_inc_max            = tx_inc_r[`ESIP_I_MAX];
	assign tx_inc_over           = tx_inc_r[`ESIP_I_OVER];
	assign tx_inc_mcast_data_err = tx_inc_r[`ESIP_I_MC_DERR];
	assign tx_inc_mcast_data_ok  = tx_inc_r[`ESIP_I_MC_DOK];
	assign tx_inc_bcast_data_err = tx_inc_r[`ESIP_I_BC_DERR];
	assign tx_inc_bcast_data_ok  = tx_inc_r[`ESIP_I_BC_DOK];
	assign tx_inc_ucast_data_err = tx_inc_r[`ESIP_I_UC_DERR];
	assign tx_inc_ucast_data_ok  = tx_inc_r[`ESIP_I_UC_DOK];
	assign tx_inc_mcast_ctrl     = tx_inc_r[`ESIP_I_MC_CTRL];
	assign tx_inc_bcast_ctrl     = tx_inc_r[`ESIP_I_BC_CTRL];
	assign tx_inc_ucast_ctrl     = tx_inc_r[`ESIP_I_UC_CTRL];
	assign tx_inc_pause          = tx_inc_r[`ESIP_I_PAUSE];
	assign tx_inc_fcs_err        = tx_inc_r[`ESIP_I_FCS];
	assign tx_inc_fragment       = tx_inc_r[`ESIP_I_FRAG];
	assign tx_inc_jabber         = tx_inc_r[`ESIP_I_JABBER];
	assign tx_inc_sizeok_fcserr  = tx_inc_r[`ESIP_I_SZOK_FCS];

	assign rx_inc_runt           = rx_inc_r[`ESIP_I_RUNT];
	assign rx_inc_64             = rx_inc_r[`ESIP_I_64];
	assign rx_inc_127            = rx_inc_r[`ESIP_I_127];
	assign rx_inc_255            = rx_inc_r[`ESIP_I_255];
	assign rx_inc_511            = rx_inc_r[`ESIP_I_511];
	assign rx_inc_1023           = rx_inc_r[`ESIP_I_1023];
	assign rx_inc_1518           = rx_inc_r[`ESIP_I_1518];
	assign rx_inc_max            = rx_inc_r[`ESIP_I_MAX];
	assign rx_inc_over           = rx_inc_r[`ESIP_I_OVER];
	assign rx_inc_mcast_data_err = rx_inc_r[`ESIP_I_MC_DERR];
	assign rx_inc_mcast_data_ok  = rx_inc_r[`ESIP_I_MC_DOK];
	assign rx_inc_bcast_data_err = rx_inc_r[`ESIP_I_BC_DERR];
	assign rx_inc_bcast_data_ok  = rx_inc_r[`ESIP_I_BC_DOK];
	assign rx_inc_ucast_data_err = rx_inc_r[`ESIP_I_UC_DERR];
	assign rx_inc_ucast_data_ok  = rx_inc_r[`ESIP_I_UC_DOK];
	assign rx_inc_mcast_ctrl     = rx_inc_r[`ESIP_I_MC_CTRL];
	assign rx_inc_bcast_ctrl     = rx_inc_r[`ESIP_I_BC_CTRL];
	assign rx_inc_ucast_ctrl     = rx_inc_r[`ESIP_I_UC_CTRL];
	assign rx_inc_pause          = rx_inc_r[`ESIP_I_PAUSE];
	assign rx_inc_fcs_err        = rx_inc_r[`ESIP_I_FCS];
	assign rx_inc_fragment       = rx_inc_r[`ESIP_I_FRAG];
	assign rx_inc_jabber         = rx_inc_r[`ESIP_I_JABBER];
	assign rx_inc_sizeok_fcserr  = rx_inc_r[`ESIP_I_SZOK_FCS];
	assign rx_inc_pause_ctrl_err = rx_inc_r[`ESIP_I_PAUSE_CERR];
	assign rx_inc_mcast_ctrl_err = rx_inc_r[`ESIP_I_MC_CERR];
	assign rx_inc_bcast_ctrl_err = rx_inc_r[`ESIP_I_BC_CERR];
	assign rx_inc_ucast_ctrl_err = rx_inc_r[`ESIP_I_UC_CERR];

endmodule

// file: tb/esip_top_properties.sv
// Checks on the increment pulses of esip_top.
// Assumes one shared clock and pulses one cycle after each done strobe.
`timescale 1ns/1ps
`include "esip_defines.svh"

module esip_top_properties #(
	parameter int LEN_W = 16
) (
	input wire logic                     clock,
	input wire logic                     rst_n,
	input wire logic                     tx_frame_done,
	input wire logic [LEN_W-1:0]         tx_frame_len,
	input wire logic                     tx_fcs_err,
	input wire logic                     tx_is_ctrl,
	input wire logic                     tx_is_pause,
	input wire esip_pkg::esip_cast_t     tx_cast,
	input wire logic [LEN_W-1:0]         tx_max_size,
	input wire logic                     rx_frame_done,
	input wire logic [LEN_W-1:0]         rx_frame_len,
	input wire logic                     rx_fcs_err,
	input wire logic                     rx_is_ctrl,
	input wire logic                     rx_is_pause,
	input wire esip_pkg::esip_cast_t     rx_cast,
	input wire logic [LEN_W-1:0]         rx_max_size,
	input wire logic [`ESIP_TX_NINC-1:0] tx_stat_inc,
	input wire logic [`ESIP_RX_NINC-1:0] rx_stat_inc
);
	wire tx_un = tx_frame_len < `ESIP_LEN_64;
	wire tx_ov = tx_frame_len > tx_max_size;
	wire tx_eq = tx_frame_len == tx_max_size;
	wire tx_er = tx_fcs_err | tx_un | tx_ov;
	wire rx_un = rx_frame_len < `ESIP_LEN_64;
	wire rx_ov = rx_frame_len > rx_max_size;
	wire rx_er = rx_fcs_err | rx_un | rx_ov;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	tx_bin_64_a: assert property (tx_frame_done && tx_frame_len == `ESIP_LEN_64
		|=> tx_stat_inc[`ESIP_I_64] && $onehot(tx_stat_inc[5:0])) else $error("tx 64 bin");
	tx_bin_top_a: assert property (tx_frame_done && tx_frame_len inside {[16'h0400:16'h05ee]}
		|=> tx_stat_inc[`ESIP_I_1518] && $onehot(tx_stat_inc[5:0])) else $error("tx top bin");
	tx_max_hit_a: assert property (tx_frame_done
		|=> tx_stat_inc[`ESIP_I_MAX] == $past(tx_eq)) else $error("tx max pulse");
	tx_over_jab_a: assert property (tx_frame_done && tx_ov
		|=> tx_stat_inc[`ESIP_I_OVER] && tx_stat_inc[`ESIP_I_JABBER] == $past(tx_fcs_err))
		else $error("tx oversize or jabber");
	tx_mc_derr_a: assert property (tx_frame_done && !tx_is_ctrl && !tx_is_pause && tx_er
		&& tx_cast == esip_pkg::ESIP_MCAST
		|=> tx_stat_inc[`ESIP_I_MC_DERR] && !tx_stat_inc[`ESIP_I_MC_DOK]) else $error("tx mc data");
	tx_pause_ok_a: assert property (tx_frame_done && tx_is_pause && !tx_er
		|=> tx_stat_inc[`ESIP_I_PAUSE] && !tx_stat_inc[`ESIP_I_FCS]) else $error("tx pause");
	tx_frag_a: assert property (tx_frame_done && tx_un && tx_fcs_err
		|=> tx_stat_inc[`ESIP_I_FRAG] && !tx_stat_inc[`ESIP_I_SZOK_FCS]) else $error("tx fragment");
	rx_runt_a: assert property (rx_frame_done && rx_un
		|=> rx_stat_inc[`ESIP_I_RUNT] && !rx_stat_inc[`ESIP_I_64]) else $error("rx runt");
	rx_fcs_err_a: assert property (rx_frame_done
		|=> rx_stat_inc[`ESIP_I_FCS] == $past(rx_fcs_err)) else $error("rx fcs pulse");
	rx_ctrl_err_a: assert property (rx_frame_done && rx_is_ctrl && rx_er
		&& rx_cast == esip_pkg::ESIP_BCAST
		|=> rx_stat_inc[`ESIP_I_BC_CERR] && !rx_stat_inc[`ESIP_I_BC_CTRL]) else $error("rx bc ctrl");
	tx_idle_quiet_a: assert property (!tx_frame_done |=> tx_stat_inc == '0)
		else $error("tx pulse without frame");
	rx_idle_quiet_a: assert property (!rx_frame_done |=> rx_stat_inc == '0)
		else $error("rx pulse without frame");
endmodule

bind esip_top esip_top_properties #(.LEN_W(LEN_W)) u_props (
	.clock(clock), .rst_n(rst_n), .tx_frame_done(tx_frame_done), .tx_frame_len(tx_frame_len),
	.tx_fcs_err(tx_fcs_err), .tx_is_ctrl(tx_is_ctrl), .tx_is_pause(tx_is_pause),
	.tx_cast(tx_cast), .tx_max_size(tx_max_size), .rx_frame_done(rx_frame_done),
	.rx_frame_len(rx_frame_len), .rx_fcs_err(rx_fcs_err), .rx_is_ctrl(rx_is_ctrl),
	.rx_is_pause(rx_is_pause), .rx_cast(rx_cast), .rx_max_size(rx_max_size),
	.tx_stat_inc(tx_stat_inc), .rx_stat_inc(rx_stat_inc)
);

// file: tb/esip_counter_model.sv
// Counters fed by the increment vectors.
// Assumes one pulse per event, sampled on the rising clock edge.
`timescale 1ns/1ps
`include "esip_defines.svh"

module esip_counter_model (
	input wire logic                     clock,
	input wire logic                     rst_n,
	input wire logic [`ESIP_TX_NINC-1:0] tx_inc,
	input wire logic [`ESIP_RX_NINC-1:0] rx_inc,
	output logic [15:0]                  tx_cnt [`ESIP_TX_NINC],
	output logic [15:0]                  rx_cnt [`ESIP_RX_NINC]
);
	always_ff @(posedge clock) begin
		for (int i = 0; i < `ESIP_TX_NINC; i++) begin
			if (!rst_n)
				tx_cnt[i] <= 16'h0000;
			else if (tx_inc[i])
				tx_cnt[i] <= tx_cnt[i] + 16'h0001;
		end
		for (int i = 0; i < `ESIP_RX_NINC; i++) begin
			if (!rst_n)
				rx_cnt[i] <= 16'h0000;
			else if (rx_inc[i])
				rx_cnt[i] <= rx_cnt[i] + 16'h0001;
		end
	end
endmodule

// file: tb/esip_top_bench.sv
// Random self-checking bench for esip_top.
// Assumes design, counter model and checker compile first.
`timescale 1ns/1ps
`include "esip_defines.svh"

module esip_top_bench;
	localparam int NFR = 3000;
	logic                 clock, rst_n, tx_dn, rx_dn, tx_fe, rx_fe, tx_ct, rx_ct, tx_pa, rx_pa;
	logic [15:0]          tx_ln, rx_ln, tx_mx, rx_mx;
	esip_pkg::esip_cast_t tx_cs, rx_cs;
	logic [21:0]          tx_vec, tx_o, tx_exp;
	logic [26:0]          rx_vec, rx_o, rx_exp;
	logic [15:0]          tx_cnt [22];
	logic [15:0]          rx_cnt [27];
	int                   tx_tot [22];
	int                   rx_tot [27];
	int                   error_cnt, n_checks;

	esip_top uut (
		.clock(clock), .rst_n(rst_n), .tx_frame_done(tx_dn), .tx_frame_len(tx_ln),
		.tx_fcs_err(tx_fe), .tx_is_ctrl(tx_ct), .tx_is_pause(tx_pa), .tx_cast(tx_cs),
		.tx_max_size(tx_mx), .rx_frame_done(rx_dn), .rx_frame_len(rx_ln), .rx_fcs_err(rx_fe),
		.rx_is_ctrl(rx_ct), .rx_is_pause(rx_pa), .rx_cast(rx_cs), .rx_max_size(rx_mx),
		.tx_stat_inc(tx_vec), .rx_stat_inc(rx_vec), .tx_inc_64(tx_o[0]), .tx_inc_127(tx_o[1]),
		.tx_inc_255(tx_o[2]), .tx_inc_511(tx_o[3]), .tx_inc_1023(tx_o[4]), .tx_inc_1518(tx_o[5]),
		.tx_inc_max(tx_o[6]), .tx_inc_over(tx_o[7]), .tx_inc_mcast_data_err(tx_o[8]),
		.tx_inc_mcast_data_ok(tx_o[9]), .tx_inc_bcast_data_err(tx_o[10]),
		.tx_inc_bcast_data_ok(tx_o[11]), .tx_inc_ucast_data_err(tx_o[12]),
		.tx_inc_ucast_data_ok(tx_o[13]), .tx_inc_mcast_ctrl(tx_o[14]), .tx_inc_bcast_ctrl(tx_o[15]),
		.tx_inc_ucast_ctrl(tx_o[16]), .tx_inc_pause(tx_o[17]), .tx_inc_fcs_err(tx_o[18]),
		.tx_inc_fragment(tx_o[19]), .tx_inc_jabber(tx_o[20]), .tx_inc_sizeok_fcserr(tx_o[21]),
		.rx_inc_64(rx_o[0]), .rx_inc_127(rx_o[1]), .rx_inc_255(rx_o[2]), .rx_inc_511(rx_o[3]),
		.rx_inc_1023(rx_o[4]), .rx_inc_1518(rx_o[5]), .rx_inc_max(rx_o[6]), .rx_inc_over(rx_o[7]),
		.rx_inc_mcast_data_err(rx_o[8]), .rx_inc_mcast_data_ok(rx_o[9]),
		.rx_inc_bcast_data_err(rx_o[10]), .rx_inc_bcast_data_ok(rx_o[11]),
		.rx_inc_ucast_data_err(rx_o[12]), .rx_inc_ucast_data_ok(rx_o[13]),
		.rx_inc_mcast_ctrl(rx_o[14]), .rx_inc_bcast_ctrl(rx_o[15]), .rx_inc_ucast_ctrl(rx_o[16]),
		.rx_inc_pause(rx_o[17]), .rx_inc_fcs_err(rx_o[18]), .rx_inc_fragment(rx_o[19]),
		.rx_inc_jabber(rx_o[20]), .rx_inc_sizeok_fcserr(rx_o[21]), .rx_inc_runt(rx_o[22]),
		.rx_inc_pause_ctrl_err(rx_o[23]), .rx_inc_mcast_ctrl_err(rx_o[24]),
		.rx_inc_bcast_ctrl_err(rx_o[25]), .rx_inc_ucast_ctrl_err(rx_o[26])
	);

	esip_counter_model u_cnt (.clock(clock), .rst_n(rst_n), .tx_inc(tx_vec), .rx_inc(rx_vec),
		.tx_cnt(tx_cnt), .rx_cnt(rx_cnt));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [26:0] fexp(input logic d, input logic [15:0] l, m,
		input logic f, c, p, input esip_pkg::esip_cast_t k);
		logic [26:0] v;
		logic        ov, un, er, cf, mc, bc, uc;
		ov = l > m;
		un = l < `ESIP_LEN_64;
		er = f | ov | un;
		cf = c | p;
		mc = k == esip_pkg::ESIP_MCAST;
		bc = k == esip_pkg::ESIP_BCAST;
		uc = k == esip_pkg::ESIP_UCAST;
		v = {cf & er & uc, cf & er & bc, cf & er & mc, p & er, un, !un & !ov & f, ov & f,
			un & f, f, p & !er, cf & !er & uc, cf & !er & bc, cf & !er & mc, !cf & !er & uc,
			!cf & er & uc, !cf & !er & bc, !cf & er & bc, !cf & !er & mc, !cf & er & mc, ov,
			l == m, l inside {[16'h0400:16'h05ee]}, l inside {[16'h0200:16'h03ff]},
			l inside {[16'h0100:16'h01ff]}, l inside {[16'h0080:16'h00ff]},
			l inside {[16'h0041:16'h007f]}, l == `ESIP_LEN_64};
		return d ? v : '0;
	endfunction

	function automatic logic [15:0] pick(input int idx, input logic [15:0] m);
		logic [15:0] c [14];
		c = '{16'h0001, 16'h003f, 16'h0040, 16'h0041, 16'h007f, 16'h0080, 16'h00ff,
			16'h0100, 16'h01ff, 16'h0200, 16'h03ff, 16'h0400, 16'h05ee, 16'h05ef};
		if (idx < 14) return c[idx];
		if (idx == 14) return m;
		if (idx == 15) return m + 16'h0001;
		if (idx == 16) return m - 16'h0001;
		return 16'($urandom_range(1, 2047));
	endfunction

	// Frames 0-15 walk length corners, then random traffic with idle gaps
	task automatic frame(input int i, output logic d, output logic [15:0] l, m,
		output logic f, c, p, output esip_pkg::esip_cast_t k);
		int r;
		r = (i < 16) ? i % 4 : int'($urandom_range(0, 3));
		d = (i < 16 || $urandom_range(0, 4) != 0) && i < NFR;
		m = (i < 16 || $urandom_range(0, 1) == 0) ? `ESIP_LEN_1518 : 16'($urandom_range(64, 1600));
		l = pick((i < 16) ? i : int'($urandom_range(0, 20)), m);
		f = (i < 16) ? i[0] : $urandom_range(0, 3) == 0;
		c = r == 2;
		p = r == 3;
		k = esip_pkg::esip_cast_t'($urandom_range(0, 2));
	endtask

	task automatic chk(input logic [26:0] seen, input logic [26:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial begin
		#(100 * 5000);
		error_cnt++;
		close_out();
	end

	initial begin
		{tx_dn, rx_dn, tx_fe, rx_fe, tx_ct, rx_ct, tx_pa, rx_pa} = '0;
		{tx_ln, rx_ln, tx_exp, rx_exp} = '0;
		{tx_mx, rx_mx} = {`ESIP_LEN_1518, `ESIP_LEN_1518};
		{tx_cs, rx_cs} = {esip_pkg::ESIP_UCAST, esip_pkg::ESIP_UCAST};
		tx_tot = '{default: 0};
		rx_tot = '{default: 0};
		rst_n = 1'b0;
		void'($urandom(32'hca86e16a));
		repeat (8) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		for (int i = 0; i <= NFR; i++) begin
			@(negedge clock);
			chk(27'(tx_vec), 27'(tx_exp));
			chk(27'(tx_o), 27'(tx_exp));
			chk(rx_vec, rx_exp);
			chk(rx_o, rx_exp);
			for (int b = 0; b < 27; b++) begin
				if (b < 22) tx_tot[b] += int'(tx_exp[b]);
				rx_tot[b] += int'(rx_exp[b]);
			end
			frame(i, tx_dn, tx_ln, tx_mx, tx_fe, tx_ct, tx_pa, tx_cs);
			frame(i, rx_dn, rx_ln, rx_mx, rx_fe, rx_ct, rx_pa, rx_cs);
			tx_exp = 22'(fexp(tx_dn, tx_ln, tx_mx, tx_fe, tx_ct, tx_pa, tx_cs));
			rx_exp = fexp(rx_dn, rx_ln, rx_mx, rx_fe, rx_ct, rx_pa, rx_cs);
		end
		@(negedge clock);
		for (int b = 0; b < 27; b++) begin
			if (b < 22) chk(27'(tx_cnt[b]), 27'(tx_tot[b]));
			chk(27'(rx_cnt[b]), 27'(rx_tot[b]));
		end
		close_out();
	end
endmodule
